/* hw/ccxd_decode.sv */
/*
 * Instruction timing and extension-word decoder. Takes one fetched word
 * per strobe, reports cycle count and word length of the instruction or
 * flags an extension word and decodes it for the following instruction.
 * Assumes fetch words arrive from logic on clk; the register file
 * answers a read of the named repeat register in the same cycle.
 */
// Notes on behaviour
// - Register source: 1 cyc to reg, 2 to PC, 4/2 words to memory.
// - Indirect/autoinc source: 2 to reg, 3 to PC, 5/2 words to memory.
// - Immediate source: 2/2 to reg, 3/2 to PC, 5/3 to memory.
// - Indexed/symbolic/absolute source: 3/2 to reg or PC, 6/3 memory.
// - Copy, bit-test and compare to memory take one cycle fewer.
// - Shift, swap, extend: 1 reg, 3 indirect, 4 indexed; no immediate.
// - Push takes 3 cycles, or 4 in indexed, symbolic, absolute modes.
// - Call 3 in register else 4; one word reg/indirect, else two.
// - Every jump is one word and two cycles, taken or not.
// - Bits 15:11 in 1800h..1fffh mark an extension word.
// - After an extension word, addresses and immediates are 20-bit.
// - Register layout only for reg-reg format I and reg format II.
// - Extended instructions without an extension word are allowed.
// - Length bit with byte/word bit selects reserved, 20, 16 or 8.
// - Repeat select 0: bits 3:0 hold count minus one immediately.
// - Repeat select 1: bits 3:0 name register holding count minus one.
// - Counts are in main clock periods, set by format and modes.
`timescale 1ns/10ps

module ccxd_decode (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  nrst,
    // Fetch side
    input  wire logic                  fetch_vld,
    input  wire logic [15:0]           fetch_word,
    // Repeat register lookup
    output logic      [3:0]            rpt_reg_sel,
    input  wire logic [3:0]            rpt_reg_val,
    // Decoded results
    output ccxd_pkg::ccxd_timing_s     timing,
    output ccxd_pkg::ccxd_ext_s        ext,
    output logic                       illegal
);
    import ccxd_pkg::*;

    // ------------------------------------------------------------------
    // Field extraction
    // ------------------------------------------------------------------
    // Raw fields of the word on the fetch bus; nothing is stored here,
    // the word is decoded in the cycle it is offered, so the fetch
    // side holds it for the strobe cycle only
    wire logic       is_ext_w;
    wire logic       is_jump_w;
    wire logic       is_f2_w;
    wire logic       is_f1_w;
    wire logic [2:0] f2_op_w;
    wire logic [3:0] f1_op_w;
    wire logic [1:0] as_w;
    wire logic       ad_w;
    wire logic       bw_w;
    wire logic [3:0] src_reg_w;
    wire logic [3:0] dst_reg_w;

    assign is_ext_w  = fetch_word[CCXD_EXT_OPC_HI:CCXD_EXT_OPC_LO]
                       == CCXD_EXT_OPC;
    assign is_jump_w = fetch_word[15:13] == CCXD_JMP_PREFIX;
    assign is_f2_w   = fetch_word[15:10] == CCXD_F2_PREFIX;
    assign is_f1_w   = fetch_word[15:14] != 2'h0;
    assign f2_op_w   = fetch_word[9:7];
    assign f1_op_w   = fetch_word[15:12];
    assign as_w      = fetch_word[CCXD_AS_LO+1:CCXD_AS_LO];
    assign ad_w      = fetch_word[CCXD_AD_BIT];
    assign bw_w      = fetch_word[CCXD_BW_BIT];
    assign src_reg_w = fetch_word[CCXD_SRC_LO+3:CCXD_SRC_LO];
    assign dst_reg_w = fetch_word[3:0];

    // ------------------------------------------------------------------
    // Addressing classes
    // ------------------------------------------------------------------
    // Constant generator registers read as register mode, no extra word
    wire logic cg_w;
    assign cg_w = (src_reg_w == CCXD_REG_CG) ||
                  (src_reg_w == CCXD_REG_SR && as_w[1]);

    ccxd_am_e src_am_w;
    ccxd_am_e dst_am_w;
    ccxd_am_e f2_am_w;

    // Source class: As 00 reg, 01 indexed, 10 indirect, 11 autoinc/imm
    // Indexed, symbolic and absolute cost the same, so one class holds
    // them all; the PC as source in mode 11 is the immediate form
    always_comb begin
        src_am_w = CCXD_AM_REG;
        if (!cg_w) begin
            case (as_w)
                2'h0:    src_am_w = CCXD_AM_REG;
                2'h1:    src_am_w = CCXD_AM_MEM;
                2'h2:    src_am_w = CCXD_AM_IND;
                2'h3:    src_am_w = (src_reg_w == CCXD_REG_PC) ?
                                    CCXD_AM_IMM : CCXD_AM_IND;
                default: src_am_w = CCXD_AM_REG;
            endcase
        end
    end

    // Destination class: memory, PC or plain register
    // Ad set always means memory; the PC row applies with Ad clear only
    assign dst_am_w = ad_w ? CCXD_AM_MEM :
                      (dst_reg_w == CCXD_REG_PC) ? CCXD_AM_PC :
                      CCXD_AM_REG;

    // Format II operand sits in the low register field
    // No constant generator here: single-operand rows have no
    // constant-source entry, so the register field is taken as
    // written
    always_comb begin
        case (as_w)
            2'h0:    f2_am_w = CCXD_AM_REG;
            2'h1:    f2_am_w = CCXD_AM_MEM;
            2'h2:    f2_am_w = CCXD_AM_IND;
            2'h3:    f2_am_w = (dst_reg_w == CCXD_REG_PC) ?
                               CCXD_AM_IMM : CCXD_AM_IND;
            default: f2_am_w = CCXD_AM_REG;
        endcase
    end

    // ------------------------------------------------------------------
    // Format I timing
    // ------------------------------------------------------------------
    logic [2:0] f1_cyc_w;
    logic [1:0] f1_len_w;
    wire  logic fast_op_w;

    // Copy, compare and bit-test never store a memory result back
    assign fast_op_w = (f1_op_w == CCXD_OP_MOV) || (f1_op_w == CCXD_OP_CMP)
                       || (f1_op_w == CCXD_OP_BIT);

    // Figures are fixed per mode pair, so no sequencing is needed and
    // the answer costs a single register stage
    // Table by source class, then destination class
    always_comb begin
        f1_cyc_w = 3'h1;
        f1_len_w = 2'h1;
        case (src_am_w)
            CCXD_AM_REG: begin
                case (dst_am_w)
                    CCXD_AM_PC:  begin f1_cyc_w = 3'h2; f1_len_w = 2'h1; end
                    CCXD_AM_MEM: begin f1_cyc_w = 3'h4; f1_len_w = 2'h2; end
                    default:     begin f1_cyc_w = 3'h1; f1_len_w = 2'h1; end
                endcase
            end
            CCXD_AM_IND: begin
                case (dst_am_w)
                    CCXD_AM_PC:  begin f1_cyc_w = 3'h3; f1_len_w = 2'h1; end
                    CCXD_AM_MEM: begin f1_cyc_w = 3'h5; f1_len_w = 2'h2; end
                    default:     begin f1_cyc_w = 3'h2; f1_len_w = 2'h1; end
                endcase
            end
            CCXD_AM_IMM: begin
                case (dst_am_w)
                    CCXD_AM_PC:  begin f1_cyc_w = 3'h3; f1_len_w = 2'h2; end
                    CCXD_AM_MEM: begin f1_cyc_w = 3'h5; f1_len_w = 2'h3; end
                    default:     begin f1_cyc_w = 3'h2; f1_len_w = 2'h2; end
                endcase
            end
            default: begin
                case (dst_am_w)
                    CCXD_AM_MEM: begin f1_cyc_w = 3'h6; f1_len_w = 2'h3; end
                    default:     begin f1_cyc_w = 3'h3; f1_len_w = 2'h2; end
                endcase
            end
        endcase
        // Ops that never write back skip the final store
        // Register and PC rows carry no store cycle, so only memory
        // destinations are shortened
        if (dst_am_w == CCXD_AM_MEM && fast_op_w) begin
            f1_cyc_w = f1_cyc_w - 3'h1;
        end
    end

    // ------------------------------------------------------------------
    // Format II timing
    // ------------------------------------------------------------------
    logic [2:0] f2_cyc_w;
    logic [1:0] f2_len_w;
    logic       f2_bad_w;

    // Return and interrupt codes are refused here; their timing lives
    // in the sequencer that owns the stack
    always_comb begin
        f2_cyc_w = 3'h1;
        f2_bad_w = 1'b0;
        case (f2_op_w)
            CCXD_F2_RRC, CCXD_F2_BYTE_SWAP_OP, CCXD_F2_RRA, CCXD_F2_SXT: begin
                case (f2_am_w)
                    CCXD_AM_REG: f2_cyc_w = 3'h1;
                    CCXD_AM_IND: f2_cyc_w = 3'h3;
                    CCXD_AM_MEM: f2_cyc_w = 3'h4;
                    default: begin
                        f2_cyc_w = 3'h1;
                        f2_bad_w = 1'b1;       // No immediate form
                    end
                endcase
            end
            CCXD_F2_PUSH: begin
                f2_cyc_w = (f2_am_w == CCXD_AM_MEM) ? 3'h4 : 3'h3;
            end
            CCXD_F2_CALL: begin
                f2_cyc_w = (f2_am_w == CCXD_AM_REG) ? 3'h3 : 3'h4;
            end
            default: begin
                // Return/interrupt rows are handled elsewhere
                f2_cyc_w = 3'h1;
                f2_bad_w = 1'b1;
            end
        endcase
    end

    // One word for register and indirect, extra word otherwise
    assign f2_len_w = (f2_am_w == CCXD_AM_REG || f2_am_w == CCXD_AM_IND) ?
                      2'h1 : 2'h2;

    // ------------------------------------------------------------------
    // Extension word decode
    // ------------------------------------------------------------------
    // Pending extension word; only used fields are kept, reserved
    // bits 10:9 and 5:4 are never looked at
    // The flag outlives idle fetch cycles on purpose: the core may
    // stall between the extension word and its instruction. A second
    // extension word simply replaces the first.
    logic       ext_pend_r;
    logic       ext_zc_r;
    logic       ext_rsel_r;
    logic       ext_al_r;
    logic [3:0] ext_cnt_r;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ext_pend_r <= 1'b0;
            ext_zc_r   <= 1'b0;
            ext_rsel_r <= 1'b0;
            ext_al_r   <= 1'b0;
            ext_cnt_r  <= 4'h0;
        end else if (fetch_vld) begin
            ext_pend_r <= is_ext_w;
            if (is_ext_w) begin
                ext_zc_r   <= fetch_word[CCXD_EXT_ZC_BIT];
                ext_rsel_r <= fetch_word[CCXD_EXT_RPT_BIT];
                ext_al_r   <= fetch_word[CCXD_EXT_AL_BIT];
                ext_cnt_r  <= fetch_word[CCXD_EXT_CNT_HI:CCXD_EXT_CNT_LO];
            end
        end
    end

    // Register layout: format I reg/reg or format II reg
    wire logic reg_layout_w;
    assign reg_layout_w = (is_f1_w && src_am_w == CCXD_AM_REG && !ad_w) ||
                          (is_f2_w && f2_am_w == CCXD_AM_REG);

    // Repeat register lookup runs while the instruction decodes
    // Limitation: the register file must answer in the same cycle, or
    // a register-sourced count is taken from a stale value
    assign rpt_reg_sel = ext_cnt_r;

    wire logic [3:0] rpt_w;
    assign rpt_w = ext_rsel_r ? rpt_reg_val : ext_cnt_r;

    // Size from length bit and byte/word bit
    // The four codes map one to one onto the size enum
    ccxd_size_e size_w;
    always_comb begin
        case ({ext_al_r, bw_w})
            2'b00:   size_w = CCXD_SZ_RSVD;
            2'b01:   size_w = CCXD_SZ_ADDR20;
            2'b10:   size_w = CCXD_SZ_WORD16;
            2'b11:   size_w = CCXD_SZ_BYTE8;
            default: size_w = CCXD_SZ_RSVD;
        endcase
    end

    // ------------------------------------------------------------------
    // Result selection
    // ------------------------------------------------------------------
    // Words without a prefix decode plainly, extended ones too
    // Priority: extension word, then jump, then format II, and format I
    // by default. Words below the format I range that are neither jump
    // nor format II fall through as refused.
    // Extension fields stay neutral unless a pending extension word
    // meets a non-extension word.
    ccxd_timing_s tim_nxt;
    ccxd_ext_s    ext_nxt;
    logic         bad_nxt;

    always_comb begin
        tim_nxt        = '{valid: fetch_vld, is_ext: 1'b0,
                           cycles: f1_cyc_w, words: f1_len_w};
        bad_nxt        = 1'b0;
        ext_nxt        = '0;
        ext_nxt.size   = CCXD_SZ_WORD16;
        if (is_ext_w) begin
            tim_nxt.is_ext = 1'b1;
            tim_nxt.cycles = CCXD_CYC_RESET;
            tim_nxt.words  = CCXD_LEN_ONE;
        end else if (is_jump_w) begin
            tim_nxt.cycles = CCXD_CYC_JUMP;
            tim_nxt.words  = CCXD_LEN_ONE;
        end else if (is_f2_w) begin
            tim_nxt.cycles = f2_cyc_w;
            tim_nxt.words  = f2_len_w;
            bad_nxt        = f2_bad_w;
        end else if (!is_f1_w) begin
            bad_nxt        = 1'b1;
        end
        if (ext_pend_r && !is_ext_w) begin
            ext_nxt.addr20          = 1'b1;
            ext_nxt.reg_layout      = reg_layout_w;
            ext_nxt.zero_carry_flag = reg_layout_w & ext_zc_r;
            ext_nxt.size            = size_w;
            ext_nxt.rpt_minus1      = reg_layout_w ? rpt_w : 4'h0;
            if (size_w == CCXD_SZ_RSVD) begin
                bad_nxt = 1'b1;        // Reserved length combination
            end
        end
        bad_nxt = bad_nxt & fetch_vld;
    end

    // Registered outputs; only valid and illegal are cleared while no word is fetched
    // All outputs are flops so the execution stage sees figures that
    // stand a whole cycle; valid low marks the idle cycles
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            timing  <= '0;
            ext     <= '0;
            illegal <= 1'b0;
        end else begin
            timing  <= tim_nxt;
            ext     <= ext_nxt;
            illegal <= bad_nxt;
        end
    end

endmodule : ccxd_decode

/* hw/ccxd_pkg.sv */
/*
 * Package for the cycle and extension-word decoder: opcode field layout,
 * addressing modes, cycle and length figures, extension-word field layout.
 * Assumes the standard 16-bit instruction word of the core.
 */
package ccxd_pkg;

    // ------------------------------------------------------------------
    // Extension word layout
    // ------------------------------------------------------------------
    localparam logic [4:0] CCXD_EXT_OPC       = 5'h03; // 1800h..1fffh
    localparam int         CCXD_EXT_OPC_HI    = 15;
    localparam int         CCXD_EXT_OPC_LO    = 11;
    localparam int         CCXD_EXT_ZC_BIT    = 8;
    localparam int         CCXD_EXT_RPT_BIT   = 7;
    localparam int         CCXD_EXT_AL_BIT    = 6;
    localparam int         CCXD_EXT_CNT_HI    = 3;
    localparam int         CCXD_EXT_CNT_LO    = 0;

    // ------------------------------------------------------------------
    // Instruction word layout
    // ------------------------------------------------------------------
    localparam int         CCXD_BW_BIT        = 6;
    localparam int         CCXD_AS_LO         = 4;
    localparam int         CCXD_AD_BIT        = 7;
    localparam int         CCXD_SRC_LO        = 8;
    localparam logic [3:0] CCXD_REG_PC        = 4'h0;
    localparam logic [3:0] CCXD_REG_SR        = 4'h2;
    localparam logic [3:0] CCXD_REG_CG        = 4'h3;

    // Format II sub-opcodes, bits 9:7 under 0001_00xx
    localparam logic [5:0] CCXD_F2_PREFIX     = 6'h04;
    localparam logic [2:0] CCXD_F2_RRC        = 3'h0;
    localparam logic [2:0] CCXD_F2_BYTE_SWAP_OP       = 3'h1;
    localparam logic [2:0] CCXD_F2_RRA        = 3'h2;
    localparam logic [2:0] CCXD_F2_SXT        = 3'h3;
    localparam logic [2:0] CCXD_F2_PUSH       = 3'h4;
    localparam logic [2:0] CCXD_F2_CALL       = 3'h5;
    localparam logic [2:0] CCXD_JMP_PREFIX    = 3'h1;

    // Format I opcodes that save a cycle on memory destinations
    localparam logic [3:0] CCXD_OP_MOV        = 4'h4;
    localparam logic [3:0] CCXD_OP_CMP        = 4'h9;
    localparam logic [3:0] CCXD_OP_BIT        = 4'hb;

    // ------------------------------------------------------------------
    // Cycle and length figures
    // ------------------------------------------------------------------
    localparam logic [2:0] CCXD_CYC_JUMP      = 3'h2;
    localparam logic [1:0] CCXD_LEN_ONE       = 2'h1;
    localparam logic [2:0] CCXD_CYC_RESET     = 3'h0;
    localparam logic [1:0] CCXD_LEN_RESET     = 2'h0;

    // Operand size classes
    typedef enum logic [1:0] {
        CCXD_SZ_RSVD,
        CCXD_SZ_ADDR20,
        CCXD_SZ_WORD16,
        CCXD_SZ_BYTE8
    } ccxd_size_e;

    // Source / destination addressing class
    typedef enum logic [2:0] {
        CCXD_AM_REG,
        CCXD_AM_IND,
        CCXD_AM_IMM,
        CCXD_AM_MEM,
        CCXD_AM_PC
    } ccxd_am_e;

    // Decoded instruction timing
    typedef struct packed {
        logic       valid;
        logic       is_ext;
        logic [2:0] cycles;
        logic [1:0] words;
    } ccxd_timing_s;

    // Decoded extension word
    typedef struct packed {
        logic       reg_layout;
        logic       zero_carry_flag;
        logic       addr20;
        ccxd_size_e size;
        logic [3:0] rpt_minus1;
    } ccxd_ext_s;

endpackage : ccxd_pkg

/* testbench/ccxd_decode_asserts.sv */
/*
 * Checker for ccxd_decode: answer timing, jump and format II figures,
 * extension word capture and its effect on the following word.
 * Assumes it is bound to the decoder and sees only its ports.
 */
`timescale 1ns/10ps

module ccxd_decode_asserts (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             nrst,
    // Fetch side and repeat lookup
    input  wire logic             fetch_vld,
    input  wire logic [15:0]      fetch_word,
    input  wire logic [3:0]       rpt_reg_sel,
    input  wire logic [3:0]       rpt_reg_val,
    // Decoded results
    input  ccxd_pkg::ccxd_timing_s timing,
    input  ccxd_pkg::ccxd_ext_s    ext,
    input  wire logic             illegal
);
    import ccxd_pkg::*;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // ------------------------------------------------------------------
    // Helper decode
    // ------------------------------------------------------------------
    logic        ext_w, f2_w, rr_w, pend_r;
    logic [15:0] ext_r;
    logic [3:0]  cnt_w, rpt_w;
    logic [1:0]  sz_w;

    // Word classes; register-register excludes extension words by 15:14
    assign ext_w = fetch_vld && fetch_word[15:11] == CCXD_EXT_OPC;
    assign f2_w  = fetch_vld && fetch_word[15:10] == CCXD_F2_PREFIX;
    assign rr_w  = fetch_vld && fetch_word[15:14] != 2'h0 &&
                   fetch_word[5:4] == 2'h0 && !fetch_word[7];
    assign cnt_w = fetch_word[3:0];
    assign rpt_w = ext_r[7] ? rpt_reg_val : ext_r[3:0];
    assign sz_w  = {ext_r[6], fetch_word[6]};

    // Pending extension, kept across idle cycles
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pend_r <= 1'b0;
            ext_r  <= 16'h0;
        end else if (fetch_vld) begin
            pend_r <= ext_w;
            ext_r  <= ext_w ? fetch_word : ext_r;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    resp_latency_a: assert property (fetch_vld |=> timing.valid)
        else $error("no answer one cycle after a fetch");
    idle_quiet_a: assert property (!fetch_vld |=> !timing.valid)
        else $error("answer without a fetch");
    jump_timing_a: assert property (fetch_vld &&
        fetch_word[15:13] == CCXD_JMP_PREFIX |=> timing.cycles ==
        CCXD_CYC_JUMP && timing.words == CCXD_LEN_ONE && !timing.is_ext)
        else $error("jump figures wrong");
    ext_flag_a: assert property (ext_w |=> timing.is_ext &&
        timing.cycles == 3'h0 && timing.words == CCXD_LEN_ONE)
        else $error("extension word not flagged");
    ext_sel_a: assert property (ext_w |=>
        rpt_reg_sel == $past(cnt_w))
        else $error("repeat register select wrong");
    reg_reg_a: assert property (rr_w && cnt_w != 4'h0 |=>
        timing.cycles == 3'h1 && timing.words == 2'h1)
        else $error("register to register figures wrong");
    shift_imm_a: assert property (f2_w &&
        fetch_word[9:7] <= CCXD_F2_SXT && fetch_word[5:0] == 6'h30
        |=> illegal)
        else $error("immediate shift not refused");
    push_mem_a: assert property (f2_w &&
        fetch_word[9:7] == CCXD_F2_PUSH && fetch_word[5:4] == 2'h1 &&
        fetch_word[3:2] != 2'h0 |=> timing.cycles == 3'h4 &&
        timing.words == 2'h2)
        else $error("push indexed figures wrong");
    call_reg_a: assert property (f2_w &&
        fetch_word[9:7] == CCXD_F2_CALL && fetch_word[5:4] == 2'h0
        |=> timing.cycles == 3'h3 && timing.words == 2'h1)
        else $error("call register figures wrong");
    addr20_a: assert property (fetch_vld && !ext_w |=>
        ext.addr20 == $past(pend_r))
        else $error("wide address flag wrong");
    size_sel_a: assert property (fetch_vld && !ext_w && pend_r &&
        fetch_word[15:14] != 2'h0 |=>
        ext.size == $past(sz_w) && illegal == ($past(sz_w) == 2'h0))
        else $error("operand size wrong");
    rpt_src_a: assert property (rr_w && pend_r |=>
        ext.reg_layout && ext.rpt_minus1 == $past(rpt_w) &&
        ext.zero_carry_flag == ext_r[8])
        else $error("register layout fields wrong");
    nonreg_a: assert property (fetch_vld && pend_r && !ext_w &&
        fetch_word[15:14] != 2'h0 && fetch_word[7] |=>
        !ext.reg_layout && ext.rpt_minus1 == 4'h0)
        else $error("memory form took register layout");

    // Main scenarios reached
    ext_seen_c: cover property (pend_r && rr_w);
    illegal_seen_c: cover property (illegal);
    jump_seen_c: cover property (fetch_vld && fetch_word[15:13] == 3'h1);

endmodule : ccxd_decode_asserts

/* testbench/testbench.sv */
/*
 * Self-checking bench for ccxd_decode: random double-operand words,
 * every single-operand op and mode, jumps, extension words and the
 * word they modify. Assumes the package is compiled first.
 */
`timescale 1ns/10ps

module testbench;
    import ccxd_pkg::*;

    localparam logic [8:0] EXT_NONE = 9'h020; // No pending extension

    logic         clk, nrst, fetch_vld, illegal;
    logic [15:0]  fetch_word, w, v;
    logic [3:0]   rpt_reg_sel, rpt_reg_val;
    logic [31:0]  seed;
    logic [15:0]  exp_q[$];
    ccxd_timing_s timing;
    ccxd_ext_s    ext;
    int           err_count, total_checks, m;

    ccxd_decode ccxd_decode_inst (.clk(clk), .nrst(nrst),
        .fetch_vld(fetch_vld), .fetch_word(fetch_word),
        .rpt_reg_sel(rpt_reg_sel), .rpt_reg_val(rpt_reg_val),
        .timing(timing), .ext(ext), .illegal(illegal));

    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    // Double-operand figures {cycles, words}
    function automatic logic [4:0] f1(input logic [15:0] i);
        int sc, c, n;
        sc = (i[5:4] == 2'h0) ? 0 : (i[5:4] == 2'h1) ? 3 :
             (i[5:4] == 2'h3 && i[11:8] == 4'h0) ? 2 : 1;
        c = (sc == 0) ? 1 : (sc == 3) ? 3 : 2;
        n = (sc >= 2) ? 2 : 1;
        if (i[7]) begin
            c = c + 3;
            n = n + 1;
            if (i[15:12] inside {CCXD_OP_MOV, CCXD_OP_CMP, CCXD_OP_BIT})
                c = c - 1;
        end else if (i[3:0] == 4'h0 && sc != 3) begin
            c = c + 1;
        end
        return {c[2:0], n[1:0]};
    endfunction : f1

    // Single-operand figures {cycles, words, illegal}; md 0 reg 1 ind
    // 2 indexed 3 immediate; refused forms report one cycle
    function automatic logic [5:0] f2(input int op, input int md);
        int c;
        logic [1:0] n;
        n = (md <= 1) ? 2'h1 : 2'h2;
        if (op <= 3) c = (md == 0) ? 1 : (md == 1) ? 3 : (md == 2) ? 4 : 0;
        else if (op == 4) c = (md == 2) ? 4 : 3;
        else if (op == 5) c = (md == 0) ? 3 : 4;
        else c = 0;
        if (c == 0) return {3'h1, n, 1'b1};
        return {c[2:0], n, 1'b0};
    endfunction : f2

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim

    // Drive one word at the falling edge and note its answer
    task automatic send(input logic [15:0] i, input logic [15:0] e);
        @(negedge clk);
        fetch_vld  = 1'b1;
        fetch_word = i;
        exp_q.push_back(e);
    endtask : send

    // Idle cycles; word flips so a stale capture shows
    task automatic gap(input int n);
        repeat (n) begin
            @(negedge clk);
            fetch_vld  = 1'b0;
            fetch_word = ~fetch_word;
        end
    endtask : gap

    // Answers are registered, so look at the falling edge
    always @(negedge clk) begin
        if (timing.valid === 1'b1) begin
            if (exp_q.size() == 0) chk(16'h0001, 16'h0000);
            else chk({timing.is_ext, timing.cycles, timing.words, illegal,
                      ext}, exp_q.pop_front());
        end
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        end_sim();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        seed = 32'd9071;
        err_count = 0;
        total_checks = 0;
        nrst = 1'b0;
        fetch_vld = 1'b0;
        fetch_word = 16'h0;
        rpt_reg_val = 4'h0;
        repeat (20) @(negedge clk);
        nrst = 1'b1;
        // Random double-operand words, back to back with odd gaps
        for (int i = 0; i < 300; i++) begin
            seed = xs(seed);
            v = seed[15:0];
            if (v[15:14] == 2'h0) v[15] = 1'b1;
            v[10] = 1'b1;
            if (v[5:4] == 2'h3 && seed[20]) v[11:8] = 4'h0;
            send(v, {1'b0, f1(v), 1'b0, EXT_NONE});
            if (seed[21]) gap(1);
        end
        // Every single-operand op in every mode
        for (int op = 0; op < 8; op++) begin
            for (int a = 0; a < 5; a++) begin
                m = (a == 0) ? 0 : (a == 1) ? 2 : (a == 4) ? 3 : 1;
                w = {6'h04, op[2:0], 1'b0, a[1:0], (a == 4) ? 4'h0 : 4'h5};
                if (a == 4) w[5:4] = 2'h3;
                send(w, {1'b0, f2(op, m), EXT_NONE});
            end
        end
        // All eight jump conditions
        for (int c = 0; c < 8; c++) begin
            seed = xs(seed);
            send({3'h1, c[2:0], seed[9:0]},
                 {1'b0, CCXD_CYC_JUMP, CCXD_LEN_ONE, 1'b0, EXT_NONE});
        end
        // Extension words, reserved bits random, then their instruction
        for (int i = 0; i < 40; i++) begin
            gap(1);
            seed = xs(seed);
            rpt_reg_val = seed[23:20];
            w = 16'h1800 | (seed[15:0] & 16'h07ff);
            v = {4'h4 + {1'b0, seed[26:24]}, 4'h6, seed[27], seed[28],
                 2'h0, 4'h9};
            send(w, {1'b1, 3'h0, CCXD_LEN_ONE, 1'b0, EXT_NONE});
            gap(seed[30:29]);
            send(v, {1'b0, f1(v),
                ({w[6], v[6]} == 2'h0), !v[7], !v[7] & w[8], 1'b1,
                w[6], v[6], v[7] ? 4'h0 : w[7] ? rpt_reg_val : w[3:0]});
        end
        gap(4);
        chk(16'(exp_q.size()), 16'h0);
        end_sim();
    end

endmodule : testbench

bind ccxd_decode ccxd_decode_asserts ccxd_decode_asserts_inst (
    .clk(clk), .nrst(nrst), .fetch_vld(fetch_vld),
    .fetch_word(fetch_word), .rpt_reg_sel(rpt_reg_sel),
    .rpt_reg_val(rpt_reg_val), .timing(timing), .ext(ext),
    .illegal(illegal));
